// *** src/hjd_jack_detect.sv ***
// Headset jack plug/unplug debouncer with event pulses and audio path steering.
// Assumes jack_sense_input is asynchronous; other inputs are on clk.
`default_nettype none
module hjd_jack_detect
   import hjd_pkg::*;
#(
   // Tick period in clocks; a bench may shorten it, the 256-tick count stays
   parameter int unsigned TICK_CYC = HJD_TICK_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic jack_sense_input,
   input wire logic io_supply_regulator,
   input wire logic [1:0] audio_path_select_command,
   input wire logic stereo_path_on,
   input wire logic mono_mode,
   input wire logic mono_both,
   output logic headset_present,
   output logic plug_event,
   output logic unplug_event,
   output logic route_headset,
   output logic left_headset_out,
   output logic right_headset_out
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [1:0] sync;
      logic [HJD_DIV_W-1:0] div;
      logic tick;
      logic cand;
      logic [HJD_DEB_W-1:0] cnt;
      logic present;
      logic reported;
      hjd_state_type st;
      logic plug;
      logic unplug;
      logic route;
      logic left_en;
      logic right_en;
   } hjd_regs_type;

   hjd_regs_type cur_ff;
   hjd_regs_type nxt_cur;
   // Inserted level, read from the second synchroniser stage only
   logic sense_ins;

   assign sense_ins = ~cur_ff.sync[1];

   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.sync = {cur_ff.sync[0], jack_sense_input};
      nxt_cur.plug = 1'b0;
      nxt_cur.unplug = 1'b0;
      nxt_cur.tick = 1'b0;
      if (cur_ff.div == HJD_DIV_W'(TICK_CYC - 1))
      begin
         nxt_cur.div = '0;
         nxt_cur.tick = 1'b1;
      end
      else
      begin
         nxt_cur.div = cur_ff.div + 1'b1;
      end
      if (sense_ins != cur_ff.cand)
      begin
         nxt_cur.cand = sense_ins;
         nxt_cur.cnt = '0;
      end
      else if (cur_ff.cand != cur_ff.present && cur_ff.tick)
      begin
         if (cur_ff.cnt == HJD_DEB_W'(HJD_DEBOUNCE_TICKS - 1))
         begin
            nxt_cur.present = cur_ff.cand;
            nxt_cur.cnt = '0;
         end
         else
         begin
            nxt_cur.cnt = cur_ff.cnt + 1'b1;
         end
      end
      else if (cur_ff.cand == cur_ff.present)
      begin
         nxt_cur.cnt = '0;
      end
      // Detection keeps running with regulator off; only events wait for it
      case (cur_ff.st)
         HJD_ST_OFF:
         begin
            if (io_supply_regulator)
               nxt_cur.st = HJD_ST_SYNC;
         end
         HJD_ST_SYNC:
         begin
            // A regulator that drops at once owes no report
            if (!io_supply_regulator)
            begin
               nxt_cur.st = HJD_ST_OFF;
            end
            else
            begin
               nxt_cur.st = HJD_ST_RUN;
               nxt_cur.plug = cur_ff.present;
               nxt_cur.reported = cur_ff.present;
            end
         end
         HJD_ST_RUN:
         begin
            if (!io_supply_regulator)
               nxt_cur.st = HJD_ST_OFF;
            else if (cur_ff.present != cur_ff.reported)
            begin
               nxt_cur.reported = cur_ff.present;
               nxt_cur.plug = cur_ff.present;
               nxt_cur.unplug = ~cur_ff.present;
            end
         end
         default: nxt_cur.st = HJD_ST_OFF;
      endcase
      // Routing depends only on the select command and the debounced state; the left output also follows the stereo path or mono setting
      nxt_cur.route = (audio_path_select_command == HJD_SEL_HEADSET)
                      || (audio_path_select_command == HJD_SEL_AUTO && cur_ff.present);
      nxt_cur.right_en = nxt_cur.route;
      nxt_cur.left_en = nxt_cur.route && (mono_mode ? mono_both : stereo_path_on);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         // Synchroniser starts at the idle pin level, so reset shows no plug
         cur_ff <= '{st: HJD_ST_OFF, sync: 2'h3, default: '0};
      else
         cur_ff <= nxt_cur;
   end

   assign headset_present = cur_ff.present;
   assign plug_event = cur_ff.plug;
   assign unplug_event = cur_ff.unplug;
   assign route_headset = cur_ff.route;
   assign left_headset_out = cur_ff.left_en;
   assign right_headset_out = cur_ff.right_en;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_plug_seen;
      !cur_ff.present ##1 cur_ff.present;
   endsequence

   sequence s_reg_rise;
      !io_supply_regulator ##1 io_supply_regulator;
   endsequence

   property p_no_event_when_off;
      @(posedge clk) disable iff (sys_rst)
      !$past(io_supply_regulator) && !io_supply_regulator |-> !plug_event && !unplug_event;
   endproperty
   a_no_event_when_off: assert property (p_no_event_when_off) else $error("event while regulator off");

   property p_present_needs_tick;
      @(posedge clk) disable iff (sys_rst)
      $changed(cur_ff.present) |-> $past(cur_ff.tick) && $past(cur_ff.cnt) == 9'h0ff;
   endproperty
   a_present_needs_tick: assert property (p_present_needs_tick) else $error("state changed early");

   property p_restart;
      @(posedge clk) disable iff (sys_rst)
      sense_ins != cur_ff.cand |=> cur_ff.cnt == 9'h000;
   endproperty
   a_restart: assert property (p_restart) else $error("count not restarted");

   property p_auto_route;
      @(posedge clk) disable iff (sys_rst)
      s_plug_seen ##0 (audio_path_select_command == 2'h3) |=> route_headset;
   endproperty
   a_auto_route: assert property (p_auto_route) else $error("auto route missed");

   property p_handset_default;
      @(posedge clk) disable iff (sys_rst)
      !cur_ff.present && audio_path_select_command != 2'h1 |=> !route_headset;
   endproperty
   a_handset_default: assert property (p_handset_default) else $error("headset route without headset");

   property p_late_plug;
      @(posedge clk) disable iff (sys_rst)
      cur_ff.st == HJD_ST_SYNC && cur_ff.present && io_supply_regulator |=> plug_event;
   endproperty
   a_late_plug: assert property (p_late_plug) else $error("power-up plug not reported");

   property p_power_up_plug;
      @(posedge clk) disable iff (sys_rst)
      s_reg_rise ##1 (io_supply_regulator && headset_present) |=> plug_event;
   endproperty
   a_power_up_plug: assert property (p_power_up_plug) else $error("plug missing after regulator rise");

   property p_unplug_real;
      @(posedge clk) disable iff (sys_rst)
      unplug_event |-> !headset_present && $past(io_supply_regulator);
   endproperty
   a_unplug_real: assert property (p_unplug_real) else $error("unplug event without cause");

   property p_polarity;
      @(posedge clk) disable iff (sys_rst)
      cur_ff.tick && cur_ff.cnt == 9'h0ff && cur_ff.cand == sense_ins && cur_ff.cand != cur_ff.present
      |=> headset_present == !$past(cur_ff.sync[1]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("sense polarity wrong");

   property p_stereo_indep;
      @(posedge clk) disable iff (sys_rst)
      $changed(stereo_path_on) |=> $stable(headset_present) || $past(cur_ff.tick);
   endproperty
   a_stereo_indep: assert property (p_stereo_indep) else $error("stereo path disturbed detect");

   property p_mono;
      @(posedge clk) disable iff (sys_rst)
      mono_mode && !mono_both |=> !left_headset_out;
   endproperty
   a_mono: assert property (p_mono) else $error("mono right-only drove left");

endmodule
`default_nettype wire

// *** src/hjd_pkg.sv ***
// Constants for the headset jack detect and debounce block.
// Assumes a 250 MHz system clock; the 32 kHz debounce tick is derived from it.
`default_nettype none
package hjd_pkg;
   localparam int unsigned HJD_CLK_HZ = 250000000;
   localparam int unsigned HJD_TICK_HZ = 32000;
   // One 32 kHz period in system clocks, rounded down
   localparam int unsigned HJD_TICK_CYC = HJD_CLK_HZ / HJD_TICK_HZ;
   localparam int unsigned HJD_DEBOUNCE_TICKS = 256;
   localparam int unsigned HJD_DEBOUNCE_MS = 8;
   localparam int unsigned HJD_DIV_W = 13;
   localparam int unsigned HJD_DEB_W = 9;
   localparam logic [1:0] HJD_SEL_AUTO = 2'h3;
   localparam logic [1:0] HJD_SEL_HANDSET = 2'h0;
   localparam logic [1:0] HJD_SEL_HEADSET = 2'h1;

   typedef enum logic [1:0]
   {
      HJD_ST_OFF = 2'b00,
      HJD_ST_SYNC = 2'b01,
      HJD_ST_RUN = 2'b11
   } hjd_state_type;
endpackage
`default_nettype wire

// *** tb/hjd_jack_model.sv ***
// Model of a headset jack with a resistive speaker load.
// Assumes the sense pin has a pull-up inside the device.
`default_nettype none
module hjd_jack_model
(
   input wire logic plugged,
   output logic sense
);
   timeunit 1ns;
   timeprecision 1ps;
   // Load pulls low, pull-up holds high when absent
   assign sense = ~plugged;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the jack debouncer.
// Assumes a shortened tick divider, so one 256-tick debounce is about two thousand clocks.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hjd_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_on = 1'b0;
   logic [1:0] sel = 2'h3;
   logic st_on = 1'b0;
   logic mono = 1'b0;
   logic both = 1'b0;
   logic plugged = 1'b0;
   logic sense;
   logic present;
   logic plug_ev;
   logic unplug_ev;
   logic route;
   logic left_out;
   logic right_out;
   // Short tick keeps the run brief; the 256-tick count is unchanged
   localparam int TB_TICK = 8;
   localparam int DEB_CYC = int'(HJD_DEBOUNCE_TICKS) * TB_TICK;
   int fail_count = 0;
   int num_checks = 0;
   int seed = 32'h478a316c;
   int waited;
   logic [1:0] exp_q[$];
   hjd_jack_model hjd_jack_model_inst(.plugged(plugged), .sense(sense));
   hjd_jack_detect #(.TICK_CYC(TB_TICK)) hjd_jack_detect_inst(.clk(clk), .sys_rst(sys_rst),
      .jack_sense_input(sense), .io_supply_regulator(reg_on),
      .audio_path_select_command(sel), .stereo_path_on(st_on), .mono_mode(mono), .mono_both(both),
      .headset_present(present), .plug_event(plug_ev), .unplug_event(unplug_ev),
      .route_headset(route), .left_headset_out(left_out), .right_headset_out(right_out));
   always #2 clk = ~clk;
   task automatic check(input logic [1:0] seen, input logic [1:0] want);
      num_checks++;
      if (seen !== want)
      begin
         fail_count++;
         $display("wrong value at %0t: saw %b want %b", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_present(input logic want, output int n);
      n = 0;
      while (present !== want && n < DEB_CYC + 4 * TB_TICK)
      begin
         @(negedge clk);
         n++;
      end
      repeat (4) @(negedge clk);
   endtask
   // Event monitor takes the oldest note
   always @(negedge clk)
      if (plug_ev === 1'b1 || unplug_ev === 1'b1)
      begin
         if (exp_q.size() == 0)
            check({plug_ev, unplug_ev}, 2'h0);
         else
            check({plug_ev, unplug_ev}, exp_q.pop_front());
      end
   initial
   begin
      // About five debounces of work; over twice that is a hang
      repeat (12 * DEB_CYC) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      {st_on, mono, both} = 3'($random(seed));
      // Plugged with module off, one bounce late in the count
      plugged = 1'b1;
      repeat (200 * TB_TICK) @(negedge clk);
      plugged = 1'b0;
      repeat (4 * TB_TICK) @(negedge clk);
      plugged = 1'b1;
      repeat (96 * TB_TICK) @(negedge clk);
      check({present, plug_ev}, 2'h0);
      wait_present(1'b1, waited);
      check({present, plug_ev}, 2'h2);
      exp_q.push_back(2'h2);
      reg_on = 1'b1;
      repeat (8) @(negedge clk);
      check({route, exp_q.size() == 0}, 2'h3);
      check({left_out, right_out}, {(mono ? both : st_on), 1'b1});
      for (int i = 0; i < 8; i++)
      begin
         {st_on, mono, both} = 3'(i);
         repeat (2) @(negedge clk);
         check({left_out, right_out}, {(mono ? both : st_on), 1'b1});
         check({present, unplug_ev}, 2'h2);
      end
      // Select 0 and 2 hand over to the handset, 1 and 3 keep the headset
      for (int i = 0; i < 4; i++)
      begin
         sel = 2'(i);
         repeat (2) @(negedge clk);
         check({route, right_out}, {2{i[0]}});
      end
      $display("test plug done");
      exp_q.push_back(2'h1);
      plugged = 1'b0;
      wait_present(1'b0, waited);
      check({waited >= DEB_CYC - TB_TICK, waited <= DEB_CYC + 4}, 2'h3);
      check({route, exp_q.size() == 0}, 2'h1);
      check({left_out, right_out}, 2'h0);
      sel = HJD_SEL_HEADSET;
      repeat (2) @(negedge clk);
      check({route, present}, 2'h2);
      sel = HJD_SEL_AUTO;
      $display("test unplug done");
      // Regulator off: changes tracked silently, nothing owed when absent
      reg_on = 1'b0;
      plugged = 1'b1;
      wait_present(1'b1, waited);
      check({present, plug_ev}, 2'h2);
      plugged = 1'b0;
      wait_present(1'b0, waited);
      reg_on = 1'b1;
      repeat (8) @(negedge clk);
      check({present, route}, 2'h0);
      check({exp_q.size() == 0, plug_ev}, 2'h2);
      $display("test regulator off done");
      print_verdict();
   end
endmodule
`default_nettype wire
